// ===== twsp_pkg.sv
// constants and types shared by the three-wire serial port
package twsp_pkg;
   // register byte addresses
   localparam logic [31:0] ADDR_MODE  = 32'h4004_2400;
   localparam logic [31:0] ADDR_CLKSEL = 32'h4004_2404;
   localparam logic [31:0] ADDR_TXBUF = 32'h4004_2408;
   localparam logic [31:0] ADDR_RXBUF = 32'h4004_240C;
   // serial_mode_control bit positions
   localparam int P_RUN_EN   = 7;
   localparam int P_TXRX     = 6;
   localparam int P_SS_USE   = 5;
   localparam int P_LSB1ST   = 4;
   localparam int P_IRQ_SRC  = 3;
   localparam int P_LEN16    = 2;
   localparam int P_RX_VALID = 1;
   localparam int P_BUSY     = 0;
   // serial_clock_select bit positions
   localparam int P_CPOL     = 4;
   localparam int P_CPHA     = 3;
   localparam int P_DIV_HI   = 2;
   localparam int CLK_FIELD_W = 5;
   // reset values
   localparam logic [5:0]  MODE_RST   = 6'h00;
   localparam logic [4:0]  CLKSEL_RST = 5'h00;
   localparam logic [15:0] BUF_RST    = 16'h0000;
   // divider code for the external serial clock
   localparam logic [2:0]  DIV_SLAVE  = 3'h7;
   // word lengths in bits
   localparam logic [4:0]  LEN_SHORT  = 5'h08;
   localparam logic [4:0]  LEN_LONG   = 5'h10;
   // bus answers
   localparam logic [1:0]  RESP_OKAY   = 2'h0;
   localparam logic [1:0]  RESP_SLVERR = 2'h2;
   // engine states
   typedef enum logic [0:0] {
      ST_IDLE = 1'b0,
      ST_RUN  = 1'b1
   } twsp_state_e;
endpackage

// ===== twsp_port.sv
// three-wire serial port with its register file on axi4-lite
//
// Functional notes
// RULE1 - port runs only while enable bit set
// RULE2 - transmit buffer write starts transfer when txrx
// RULE3 - receive buffer read starts receive-only reception
// RULE4 - serial data out low in receive-only mode
// RULE5 - slave-select use bit gates the select pin
// RULE6 - software fixes select pin before enabling use
// RULE7 - bit order msb or lsb first
// RULE8 - interrupt at end or tx buffer empty
// RULE9 - word length 8 or 16 bits
// RULE10 - rx valid set on data, cleared on read
// RULE11 - busy bit shows communication in progress
// RULE12 - two low mode bits are read-only
// RULE13 - software keeps mode fields steady while busy
// RULE14 - mode and clock select reset to zero
// RULE15 - polarity and phase pick four timing types
// RULE16 - reset gives timing type one
// RULE17 - clock field selects divider or slave clock
// RULE18 - clock select writes blocked while enabled
// RULE19 - transmit word shifted out serially
// RULE20 - serial input assembled into receive buffer
// RULE21 - buffers reset to zero, byte accessible
// RULE22 - software enables port clock gate first
// RULE23 - busy on start, interrupt and clear at end
// RULE24 - slave waits for external master clock
// RULE25 - one bit per serial clock, 8 or 16
//
// Decided for this implementation: register access over AXI4-Lite.
`timescale 1ns/10ps
module twsp_port (
   input  wire logic        mclk,
   input  wire logic        rst,
   // axi4-lite slave
   input  wire logic [31:0] s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [31:0] s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // serial link
   input  wire logic        sck_in,
   output logic             sck_out,
   output logic             sck_oe,
   output logic             sdo,
   output logic             sdo_oe,
   input  wire logic        sdi,
   input  wire logic        slave_select_pin_n,
   output logic             port_interrupt
);
   // register state
   logic [5:0]  mode_q;
   logic [4:0]  clksel_q;
   logic [15:0] tx_buf_q;
   logic [15:0] rx_buf_q;
   logic        rx_valid_q;
   logic        tx_full_q;
   logic        rx_req_q;
   // bus state
   logic        aw_hold_q;
   logic        w_hold_q;
   logic [31:0] awaddr_q;
   logic [31:0] wdata_q;
   logic [3:0]  wstrb_q;
   logic        bvalid_q;
   logic [1:0]  bresp_q;
   logic        rvalid_q;
   logic [31:0] rdata_q;
   logic [1:0]  rresp_q;
   // engine state
   twsp_pkg::twsp_state_e state_q;
   logic [15:0] tx_sh_q;
   logic [15:0] rx_sh_q;
   logic [15:0] rx_sh_d;
   logic [4:0]  bits_q;
   logic [4:0]  bits_d;
   logic [5:0]  half_q;
   logic [5:0]  half_len;
   logic        sck_q;
   logic        sck_prev_q;
   logic        first_q;
   logic        irq_q;
   // decoded fields
   logic [7:0]  mode_rd;
   logic        run_en;
   logic        txrx;
   logic        ss_use;
   logic        lsb1st;
   logic        irq_src;
   logic        len16;
   logic        cpol;
   logic        cpha;
   logic [2:0]  div_code;
   logic        slave;
   logic        busy;
   logic [4:0]  len;
   // events
   logic        wr_go;
   logic        rd_go;
   logic        rx_read;
   logic        tx_write;
   logic        load;
   logic        sel_ok;
   logic        m_tick;
   logic        s_edge;
   logic        lead_ev;
   logic        trail_ev;
   logic        sample_ev;
   logic        shift_ev;
   logic        done_ev;
   logic [15:0] rx_word;

   assign busy     = (state_q == twsp_pkg::ST_RUN);           // [RULE11]
   assign mode_rd  = {mode_q, rx_valid_q, busy};              // [RULE12]
   assign run_en   = mode_rd[twsp_pkg::P_RUN_EN];
   assign txrx     = mode_rd[twsp_pkg::P_TXRX];
   assign ss_use   = mode_rd[twsp_pkg::P_SS_USE];
   assign lsb1st   = mode_rd[twsp_pkg::P_LSB1ST];
   assign irq_src  = mode_rd[twsp_pkg::P_IRQ_SRC];
   assign len16    = mode_rd[twsp_pkg::P_LEN16];
   assign cpol     = clksel_q[twsp_pkg::P_CPOL];              // [RULE15]
   assign cpha     = clksel_q[twsp_pkg::P_CPHA];              // [RULE15]
   assign div_code = clksel_q[twsp_pkg::P_DIV_HI:0];
   assign slave    = (div_code == twsp_pkg::DIV_SLAVE);       // [RULE17]
   assign len      = len16 ? twsp_pkg::LEN_LONG
                           : twsp_pkg::LEN_SHORT;             // [RULE9]

   // ---------------- axi4-lite slave ----------------
   assign s_axi_awready = !aw_hold_q && !bvalid_q;
   assign s_axi_wready  = !w_hold_q && !bvalid_q;
   assign s_axi_bvalid  = bvalid_q;
   assign s_axi_bresp   = bresp_q;
   assign s_axi_arready = !rvalid_q;
   assign s_axi_rvalid  = rvalid_q;
   assign s_axi_rdata   = rdata_q;
   assign s_axi_rresp   = rresp_q;

   assign wr_go    = aw_hold_q && w_hold_q && !bvalid_q;
   assign rd_go    = s_axi_arvalid && !rvalid_q;
   assign rx_read  = rd_go && (s_axi_araddr == twsp_pkg::ADDR_RXBUF);
   assign tx_write = wr_go && (awaddr_q == twsp_pkg::ADDR_TXBUF)
                     && (wstrb_q[1:0] != 2'h0);

   // write address and data held until both are in
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         aw_hold_q <= 1'b0;
         w_hold_q  <= 1'b0;
         awaddr_q  <= 32'h0000_0000;
         wdata_q   <= 32'h0000_0000;
         wstrb_q   <= 4'h0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_hold_q <= 1'b1;
            awaddr_q  <= s_axi_awaddr;
         end else if (wr_go) begin
            aw_hold_q <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_hold_q <= 1'b1;
            wdata_q  <= s_axi_wdata;
            wstrb_q  <= s_axi_wstrb;
         end else if (wr_go) begin
            w_hold_q <= 1'b0;
         end
      end
   end

   // write response
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         bvalid_q <= 1'b0;
         bresp_q  <= twsp_pkg::RESP_OKAY;
      end else if (wr_go) begin
         bvalid_q <= 1'b1;
         case (awaddr_q)
            twsp_pkg::ADDR_MODE,
            twsp_pkg::ADDR_CLKSEL,
            twsp_pkg::ADDR_TXBUF,
            twsp_pkg::ADDR_RXBUF: bresp_q <= twsp_pkg::RESP_OKAY;
            default:              bresp_q <= twsp_pkg::RESP_SLVERR;
         endcase
      end else if (s_axi_bready) begin
         bvalid_q <= 1'b0;
      end
   end

   // read channel
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         rvalid_q <= 1'b0;
         rdata_q  <= 32'h0000_0000;
         rresp_q  <= twsp_pkg::RESP_OKAY;
      end else if (rd_go) begin
         rvalid_q <= 1'b1;
         rresp_q  <= twsp_pkg::RESP_OKAY;
         case (s_axi_araddr)
            twsp_pkg::ADDR_MODE:   rdata_q <= {24'h00_0000, mode_rd};
            twsp_pkg::ADDR_CLKSEL: rdata_q <= {27'h000_0000, clksel_q};
            twsp_pkg::ADDR_TXBUF:  rdata_q <= {16'h0000, tx_buf_q};
            twsp_pkg::ADDR_RXBUF:  rdata_q <= {16'h0000, rx_buf_q};
            default: begin
               rdata_q <= 32'h0000_0000;
               rresp_q <= twsp_pkg::RESP_SLVERR;
            end
         endcase
      end else if (s_axi_rready) begin
         rvalid_q <= 1'b0;
      end
   end

   // ---------------- registers ----------------
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         mode_q <= twsp_pkg::MODE_RST;                        // [RULE14]
      end else if (wr_go && wstrb_q[0]
                   && awaddr_q == twsp_pkg::ADDR_MODE) begin
         mode_q <= wdata_q[7:2];                              // [RULE12]
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         clksel_q <= twsp_pkg::CLKSEL_RST;              // [RULE14] [RULE16]
      end else if (wr_go && wstrb_q[0] && !run_en
                   && awaddr_q == twsp_pkg::ADDR_CLKSEL) begin
         clksel_q <= wdata_q[twsp_pkg::CLK_FIELD_W-1:0];      // [RULE18]
      end
   end

   // transmit buffer with byte lanes
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         tx_buf_q <= twsp_pkg::BUF_RST;                       // [RULE21]
      end else if (wr_go && awaddr_q == twsp_pkg::ADDR_TXBUF) begin
         if (wstrb_q[0]) begin
            tx_buf_q[7:0] <= wdata_q[7:0];                    // [RULE21]
         end
         if (wstrb_q[1]) begin
            tx_buf_q[15:8] <= wdata_q[15:8];                  // [RULE21]
         end
      end
   end

   // pending start requests; a new request wins over the load
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         tx_full_q <= 1'b0;
         rx_req_q  <= 1'b0;
      end else if (!run_en) begin
         tx_full_q <= 1'b0;                                   // [RULE1]
         rx_req_q  <= 1'b0;
      end else begin
         if (tx_write && txrx) begin
            tx_full_q <= 1'b1;                                // [RULE2]
         end else if (load) begin
            tx_full_q <= 1'b0;
         end
         if (rx_read && !txrx) begin
            rx_req_q <= 1'b1;                                 // [RULE3]
         end else if (load) begin
            rx_req_q <= 1'b0;
         end
      end
   end

   // receive buffer and its valid flag; set wins over the read clear
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         rx_buf_q   <= twsp_pkg::BUF_RST;                     // [RULE21]
         rx_valid_q <= 1'b0;
      end else begin
         if (done_ev) begin
            rx_buf_q   <= rx_word;                            // [RULE20]
            rx_valid_q <= 1'b1;                               // [RULE10]
         end else if (rx_read) begin
            rx_valid_q <= 1'b0;                               // [RULE10]
         end
      end
   end

   // ---------------- serial engine ----------------
   assign load = (state_q == twsp_pkg::ST_IDLE) && run_en
                 && (txrx ? tx_full_q : rx_req_q);            // [RULE2] [RULE3]

   // select pin only matters as a slave with use enabled
   assign sel_ok = !ss_use || !slave_select_pin_n;            // [RULE5]

   assign half_len = (div_code == 3'h0) ? 6'h01
                     : 6'(6'h01 << (div_code - 3'h1));        // [RULE17]
   assign m_tick = !slave && (half_q == 6'h01);
   assign s_edge = slave && sel_ok && (sck_in != sck_prev_q); // [RULE24]

   assign lead_ev  = busy && (slave ? (s_edge && sck_in != cpol)
                                    : (m_tick && sck_q == cpol));
   assign trail_ev = busy && (slave ? (s_edge && sck_in == cpol)
                                    : (m_tick && sck_q != cpol));
   assign sample_ev = cpha ? trail_ev : lead_ev;              // [RULE15]
   assign shift_ev  = cpha ? (lead_ev && !first_q) : trail_ev;
   assign bits_d    = sample_ev ? 5'(bits_q + 5'h01) : bits_q;
   assign done_ev   = trail_ev && (bits_d == len);            // [RULE25]

   always_comb begin
      rx_sh_d = rx_sh_q;
      if (sample_ev) begin
         if (lsb1st) begin
            rx_sh_d = {sdi, rx_sh_q[15:1]};                   // [RULE7]
         end else begin
            rx_sh_d = {rx_sh_q[14:0], sdi};                   // [RULE7]
         end
      end
   end

   // lsb-first short words collect in the upper byte
   assign rx_word = (lsb1st && !len16) ? {8'h00, rx_sh_d[15:8]}
                                       : rx_sh_d;             // [RULE20]

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         state_q <= twsp_pkg::ST_IDLE;
      end else begin
         case (state_q)
            twsp_pkg::ST_IDLE: begin
               if (load) begin
                  state_q <= twsp_pkg::ST_RUN;                // [RULE23]
               end
            end
            twsp_pkg::ST_RUN: begin
               if (!run_en || done_ev) begin
                  state_q <= twsp_pkg::ST_IDLE;         // [RULE1] [RULE23]
               end
            end
            default: state_q <= twsp_pkg::ST_IDLE;
         endcase
      end
   end

   // shift registers and bit count
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         tx_sh_q <= 16'h0000;
         rx_sh_q <= 16'h0000;
         bits_q  <= 5'h00;
         first_q <= 1'b0;
      end else if (load) begin
         tx_sh_q <= tx_buf_q;                                 // [RULE19]
         rx_sh_q <= 16'h0000;
         bits_q  <= 5'h00;
         first_q <= 1'b1;
      end else begin
         rx_sh_q <= rx_sh_d;
         bits_q  <= bits_d;                                   // [RULE25]
         if (lead_ev) begin
            first_q <= 1'b0;
         end
         if (shift_ev) begin
            if (lsb1st) begin
               tx_sh_q <= {1'b0, tx_sh_q[15:1]};              // [RULE19]
            end else begin
               tx_sh_q <= {tx_sh_q[14:0], 1'b0};              // [RULE19]
            end
         end
      end
   end

   // master clock divider; the idle level follows polarity
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         half_q <= 6'h01;
         sck_q  <= 1'b0;
      end else if (load || !busy) begin
         half_q <= half_len;
         sck_q  <= cpol;                                      // [RULE15]
      end else if (!slave) begin
         if (m_tick) begin
            half_q <= half_len;                               // [RULE17]
            sck_q  <= !sck_q;
         end else begin
            half_q <= 6'(half_q - 6'h01);
         end
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         sck_prev_q <= 1'b0;
      end else begin
         sck_prev_q <= sck_in;
      end
   end

   // interrupt: end of word, or transmit buffer taken
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= (irq_src && txrx) ? load : done_ev;         // [RULE8]
      end
   end

   assign port_interrupt = irq_q;
   assign sck_oe  = run_en && !slave;
   assign sck_out = busy ? sck_q : cpol;
   assign sdo_oe  = run_en && (!slave || sel_ok);
   assign sdo     = txrx && (lsb1st ? tx_sh_q[0]
                             : (len16 ? tx_sh_q[15] : tx_sh_q[7])); // [RULE4]

endmodule // twsp_port

// ===== twsp_peer.sv
// behavioural serial device on the far side of the port, timing type 1
`timescale 1ns/10ps
module twsp_peer (
   input  wire logic        sck,
   input  wire logic        mosi,
   input  wire logic        load,
   input  wire logic [15:0] word,
   output logic             miso,
   output logic [15:0]      cap
);
   logic [15:0] sh_q;
   initial sh_q = 16'hA5C3;
   initial cap = 16'h0000;
   assign miso = sh_q[15];
   always @(posedge load)
      sh_q <= word;
   // shift on trailing edge; refill with a toggling pattern past the word
   always @(negedge sck)
      sh_q <= {sh_q[14:0], ~sh_q[15]};
   always @(posedge sck)
      cap <= {cap[14:0], mosi};
endmodule // twsp_peer

// ===== twsp_port_monitor.sv
// assertion checker watching the ports of the serial port
`timescale 1ns/10ps
module twsp_port_monitor (
   input wire logic        mclk,
   input wire logic        rst,
   input wire logic [31:0] s_axi_awaddr,
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic [1:0]  s_axi_bresp,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic        s_axi_rvalid,
   input wire logic        sck_out,
   input wire logic        sck_oe,
   input wire logic        sdo,
   input wire logic        sdo_oe,
   input wire logic        port_interrupt
);
   logic [7:0] mode_q;
   logic [4:0] clk_q;
   logic [7:0] hi_q;
   logic [4:0] rise_q;
   logic       map_q;
   logic       lvl;
   logic       wr_hs;
   int         half;
   assign lvl = sck_out ^ clk_q[4];
   assign wr_hs = s_axi_awvalid && s_axi_awready && s_axi_wvalid
                  && s_axi_wready;
   assign half = (clk_q[2:0] == 3'h0) ? 1 : 1 << (clk_q[2:0] - 3'h1);
   // shadow of the control registers
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         mode_q <= 8'h00;
         clk_q  <= 5'h00;
         map_q  <= 1'b0;
      end else if (wr_hs) begin
         map_q <= s_axi_awaddr[31:4] == 28'h4004240;
         if (s_axi_awaddr == twsp_pkg::ADDR_MODE)
            mode_q <= s_axi_wdata[7:0] & 8'hFC;
         if (s_axi_awaddr == twsp_pkg::ADDR_CLKSEL && !mode_q[7])
            clk_q <= s_axi_wdata[4:0];
      end
   end
   // high-phase length and leading edges within a word
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         hi_q   <= 8'h00;
         rise_q <= 5'h00;
      end else begin
         hi_q <= lvl ? hi_q + 8'h01 : 8'h00;
         if (port_interrupt || !mode_q[7])
            rise_q <= 5'h00;
         else if (lvl && hi_q == 8'h00)
            rise_q <= rise_q + 5'h01;
      end
   end
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (rst);
   a_sdo_low_rx: assert property (
      !mode_q[6] && !$past(mode_q[6]) |-> !sdo) else $error("sdo high");
   a_stop_quiet: assert property (
      !mode_q[7] && !$past(mode_q[7]) |-> !sck_oe && !sdo_oe)
      else $error("pins driven while stopped");
   a_clk_dir: assert property (
      mode_q[7] && $past(mode_q[7]) && $stable(clk_q)
      |-> sck_oe == (clk_q[2:0] != twsp_pkg::DIV_SLAVE))
      else $error("sck_oe wrong");
   a_half_per: assert property (
      mode_q[7] && $past(mode_q[7]) && clk_q[2:0] != 3'h7 && !lvl
      && hi_q != 8'h00 |-> hi_q == half) else $error("sck half period");
   a_word_len: assert property (
      port_interrupt && !mode_q[3] && clk_q[2:0] != 3'h7 |-> rise_q ==
      (mode_q[2] ? twsp_pkg::LEN_LONG : twsp_pkg::LEN_SHORT))
      else $error("sck edge count");
   a_irq_pulse: assert property (
      port_interrupt |=> !port_interrupt) else $error("irq too long");
   a_wr_resp: assert property (wr_hs |-> ##2 s_axi_bvalid && s_axi_bresp ==
      (map_q ? twsp_pkg::RESP_OKAY : twsp_pkg::RESP_SLVERR))
      else $error("write response");
   a_rd_resp: assert property (s_axi_arvalid && s_axi_arready
      |=> s_axi_rvalid) else $error("read response late");
   c_word_end: cover property (port_interrupt && !mode_q[3]);
   c_empty_irq: cover property (port_interrupt && mode_q[3]);
   c_rx_only: cover property (mode_q[7] && !mode_q[6] && lvl);
endmodule // twsp_port_monitor
bind twsp_port twsp_port_monitor u_twsp_port_monitor (.*);

// ===== three_wire_serial_port_regs_tb_top.sv
// self-checking bench for the three-wire serial port
`timescale 1ns/10ps
module three_wire_serial_port_regs_tb_top;
   logic        mclk, rst, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
   logic        s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
   logic        s_axi_arready, s_axi_rvalid, s_axi_rready, sck_in, sck_out;
   logic        sck_oe, sdo, sdo_oe, sdi, slave_select_pin_n, port_interrupt;
   logic        load, pol;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic [3:0]  s_axi_wstrb;
   logic [15:0] word, cap;
   logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
   logic [33:0] exp_q[$];
   int          n_mismatch, n_compared;
   twsp_port u_twsp_port (.*);
   twsp_peer u_twsp_peer (.sck(sck_out ^ pol), .mosi(sdo), .miso(sdi),
                          .load(load), .word(word), .cap(cap));
   initial begin
      mclk = 1'b0;
      forever #4 mclk = ~mclk;
   end
   task automatic check(input string nm, input logic [33:0] seen, exp);
      n_compared++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic test_done;
      $display("compared %0d mismatches %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task automatic give_up;
      n_mismatch++;
      test_done();
   endtask
   function automatic logic [33:0] okv(input logic [31:0] v);
      okv = {twsp_pkg::RESP_OKAY, v};
   endfunction
   function automatic logic [15:0] rev(input logic [15:0] v, input int n);
      rev = 16'h0000;
      for (int i = 0; i < n; i++) rev[i] = v[n - 1 - i];
   endfunction
   task automatic wr(input logic [31:0] a, d);
      int i;
      s_axi_awaddr  <= a;
      s_axi_wdata   <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      for (i = 0; i < 50; i++) begin
         @(posedge mclk);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid) break;
      end
      if (i == 50) give_up();
   endtask
   task automatic rd(input logic [31:0] a, input logic [33:0] e);
      int i;
      exp_q.push_back(e);
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      for (i = 0; i < 50; i++) begin
         @(posedge mclk);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid) break;
      end
      if (i == 50) give_up();
   endtask
   task automatic wait_irq(output int c);
      for (c = 0; c < 2000; c++) begin
         @(posedge mclk);
         if (port_interrupt) break;
      end
      if (c == 2000) give_up();
   endtask
   // read results are compared against the oldest note
   always @(posedge mclk)
      if (s_axi_rvalid && s_axi_rready)
         check("read", {s_axi_rresp, s_axi_rdata}, (exp_q.size() > 0) ?
               exp_q.pop_front() : 34'h3_FFFF_FFFF);
   initial begin
      int          c, n, h;
      logic [15:0] a, m;
      logic [7:0]  md;
      logic [4:0]  cs;
      {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, sck_in, load, pol} = 6'h00;
      {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = 96'h0;
      {rst, s_axi_bready, s_axi_rready} = 3'h7;
      {s_axi_wstrb, word} = 20'hF0000;
      slave_select_pin_n = 1'b1; // fixed level before any use
      void'($urandom(60750));
      repeat (3) @(posedge mclk);
      rst <= 1'b0;
      @(posedge mclk);
      rd(twsp_pkg::ADDR_MODE, okv(0));
      rd(twsp_pkg::ADDR_CLKSEL, okv(0));
      rd(twsp_pkg::ADDR_TXBUF, okv(0));
      rd(twsp_pkg::ADDR_RXBUF, okv(0));
      rd(32'h4004_2410, {twsp_pkg::RESP_SLVERR, 32'h0});
      wr(32'h4004_2410, 32'h0);
      wr(twsp_pkg::ADDR_MODE, 32'h3);
      rd(twsp_pkg::ADDR_MODE, okv(0));
      // four divider codes, both orders, both lengths, both irq sources
      for (int k = 0; k < 4; k++) begin
         n = k[1] ? 16 : 8;
         h = (k < 2) ? 1 : 1 << (k - 1);
         md = {2'b11, 1'b0, k[0], k == 3, k[1], 2'b00};
         cs = {k == 2, 1'b0, 3'(k)};
         a = 16'($urandom);
         wr(twsp_pkg::ADDR_CLKSEL, cs); // written while stopped
         pol <= cs[twsp_pkg::P_CPOL];
         rd(twsp_pkg::ADDR_CLKSEL, okv(cs));
         word <= 16'($urandom);
         load <= 1'b1;
         wr(twsp_pkg::ADDR_MODE, md); // port enabled, idle
         load <= 1'b0;
         wr(twsp_pkg::ADDR_TXBUF, a);
         wait_irq(c);
         check("irq time", c, (k == 3) ? 0 : 2 * h * n);
         if (k == 3) repeat (2 * h * n + 2) @(posedge mclk);
         m = word >> (16 - n);
         check("sent", cap & (16'hFFFF >> (16 - n)),
               k[0] ? rev(a, n) : a & (16'hFFFF >> (16 - n)));
         rd(twsp_pkg::ADDR_MODE, okv(md | 8'h02));
         rd(twsp_pkg::ADDR_RXBUF, okv(k[0] ? rev(m, n) : m));
         rd(twsp_pkg::ADDR_MODE, okv(md));
         wr(twsp_pkg::ADDR_MODE, 32'h0);
      end
      // receive-only: each read of the buffer starts a word
      word <= 16'($urandom);
      load <= 1'b1;
      wr(twsp_pkg::ADDR_CLKSEL, 32'h1);
      wr(twsp_pkg::ADDR_MODE, 32'h80);
      load <= 1'b0;
      rd(twsp_pkg::ADDR_RXBUF, okv(rev(m, 16)));
      wait_irq(c);
      check("rx only sdo", cap[7:0], 0);
      rd(twsp_pkg::ADDR_RXBUF, okv(word[15:8]));
      wr(twsp_pkg::ADDR_MODE, 32'h0);
      rd(twsp_pkg::ADDR_MODE, okv(0)); // abort on stop
      // slave mode waits for an outside clock; clock select locked
      wr(twsp_pkg::ADDR_CLKSEL, 32'h7);
      wr(twsp_pkg::ADDR_MODE, 32'hE0);
      wr(twsp_pkg::ADDR_CLKSEL, 32'h1);
      rd(twsp_pkg::ADDR_CLKSEL, okv(7));
      wr(twsp_pkg::ADDR_TXBUF, 32'($urandom));
      // outside clock edges while deselected are ignored
      repeat (4) @(posedge mclk) sck_in <= ~sck_in;
      rd(twsp_pkg::ADDR_MODE, okv(32'hE1));
      slave_select_pin_n <= 1'b0;
      repeat (16) @(posedge mclk) sck_in <= ~sck_in;
      wait_irq(c);
      rd(twsp_pkg::ADDR_MODE, okv(32'hE2));
      rd(twsp_pkg::ADDR_RXBUF, okv({8{sdi}}));
      wr(twsp_pkg::ADDR_MODE, 32'h0);
      rd(twsp_pkg::ADDR_MODE, okv(0));
      repeat (2) @(posedge mclk);
      test_done();
   end
endmodule // three_wire_serial_port_regs_tb_top
